// ---- rtl/mgmt_link_if.sv ----
/*
  Two-party serial management link: clock from the station, one shared
  data line with a pull-up.
  Assumes at most one party enables its driver at a time.
*/
`timescale 1ns/1ps
`default_nettype none
interface mgmt_link_if;
  logic mdc;
  logic sta_mdio_out;
  logic sta_mdio_oe;
  logic phy_mdio_out;
  logic phy_mdio_oe;
  logic mdio;

  // Pull-up holds the line high when nobody drives
  assign mdio = sta_mdio_oe ? sta_mdio_out : (phy_mdio_oe ? phy_mdio_out : 1'b1);

  modport station (output mdc, output sta_mdio_out, output sta_mdio_oe, input mdio);
  modport phy     (input mdc, input mdio, output phy_mdio_out, output phy_mdio_oe);
endinterface
`default_nettype wire

// ---- rtl/mgmt_serial_pkg.sv ----
/*
  Shared constants and types for the serial management link: frame codes,
  field widths, indirect-access register layout, timing counts.
  Assumes a 125 MHz system clock on both ends of the link.
*/
package mgmt_serial_pkg;

  // Timing
  localparam int CLK_MHZ             = 125;
  localparam int MDC_MAX_MHZ         = 24;
  localparam int MDC_MIN_HALF_CYCLES = (CLK_MHZ + 2 * MDC_MAX_MHZ - 1) / (2 * MDC_MAX_MHZ);
  // One extra cycle leaves room for the pin synchronisers on both ends
  localparam int MDC_HALF_CYCLES     = MDC_MIN_HALF_CYCLES + 1;
  localparam int SETTLE_MS           = 50;
  localparam int SETTLE_CYCLES       = SETTLE_MS * CLK_MHZ * 1000;
  localparam int SETTLE_W            = 23;

  // Frame layout
  localparam logic [1:0] START_CODE = 2'b01;
  localparam logic [1:0] OP_READ    = 2'b10;
  localparam logic [1:0] OP_WRITE   = 2'b01;
  localparam logic [1:0] TA_WRITE   = 2'b10;
  localparam int HDR_BITS   = 12;
  localparam int DATA_BITS  = 16;
  localparam int FRAME_BITS = 34;
  localparam int RD_DATA_FIRST = 17;
  localparam int RD_DATA_LAST  = 32;
  localparam int STA_DRIVE_RD  = 15;

  // Register map
  localparam logic [4:0]  REG_CTRL      = 5'h0d;
  localparam logic [4:0]  REG_WINDOW    = 5'h0e;
  localparam logic [15:0] NUM_STD_REGS  = 16'h0020;
  localparam int          CTRL_FUNC_HI  = 15;
  localparam int          CTRL_FUNC_LO  = 14;
  localparam int          CTRL_DEV_HI   = 4;
  localparam int          CTRL_DEV_LO   = 0;
  localparam logic [1:0]  FUNC_ADDR     = 2'b00;
  localparam logic [1:0]  FUNC_DATA     = 2'b01;
  localparam logic [4:0]  DEV_VENDOR    = 5'h1f;
  localparam logic [4:0]  DEV_ENERGY_A  = 5'h03;
  localparam logic [4:0]  DEV_ENERGY_B  = 5'h07;
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] PTR_RESET     = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_START = 3'b001,
    ST_HDR   = 3'b010,
    ST_TA    = 3'b011,
    ST_DATA  = 3'b100
  } frame_state_type;

endpackage

// ---- rtl/phy_mgmt_end.sv ----
/*
  Device end of the serial management link: frame decoder, indirect
  extended-register window, strap address capture, and a register access
  port toward the device's register storage.
  Assumes the register storage answers acc_rdata_i one cycle after acc_req_o.
*/
// Notes on behaviour
// - Station makes clock, at most 24 MHz.
// - Works with management clock stopped when idle.
// - Data bits sampled on management clock rising; the station takes read bits late in the high phase instead.
// - Three-bit address latched from straps after reset.
// - Station waits after reset before first frame.
// - Direct frames address 32 registers directly.
// - Every frame opens with start pattern 01.
// - Read turnaround: release, then zero, then data.
// - Write turnaround 10 driven by station only.
// - Standard registers also reachable through window.
// - Window cannot reach control or window registers.
// - Control bits 4..0 select extended set.
// - Only sets 31, 3, 7 honoured.
// - Control bits 15..14 choose address or data.
// - Function 00: window accesses the pointer.
// - Function 01: window reaches pointed register.
// - Software loads pointer before data accesses.
// - Extended write sequence uses 0x001F, 0x401F.
// - Pointer never advances on data accesses.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_end (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  mgmt_link_if.phy         link,
  input  wire logic [2:0]  strap_addr_i,
  output logic      [2:0]  phy_addr_o,
  output logic      [15:0] ctrl_o,
  output logic      [15:0] ptr_o,
  output logic             acc_req_o,
  output logic             acc_we_o,
  output logic             acc_ext_o,
  output logic      [4:0]  acc_dev_o,
  output logic      [15:0] acc_addr_o,
  output logic      [15:0] acc_wdata_o,
  input  wire logic [15:0] acc_rdata_i
);
  import mgmt_serial_pkg::*;

  logic            mdc_meta_ff;
  logic            mdc_sync_ff;
  logic            mdc_prev_ff;
  logic            mdio_meta_ff;
  logic            mdio_sync_ff;
  logic [2:0]      strap_meta_ff;
  logic [2:0]      strap_sync_ff;
  logic [1:0]      strap_cnt_ff;
  logic [2:0]      addr_ff;
  frame_state_type state_ff;
  logic [4:0]      cnt_ff;
  logic [11:0]     hdr_ff;
  logic            last_bit_ff;
  logic            hit_ff;
  logic            is_read_ff;
  logic [15:0]     wdata_ff;
  logic [15:0]     rd_data_ff;
  logic            rd_pend_ff;
  logic [15:0]     ctrl_ff;
  logic [15:0]     ptr_ff;
  logic            out_ff;
  logic            oe_ff;
  logic            acc_req_ff;
  logic            acc_we_ff;
  logic            acc_ext_ff;
  logic [4:0]      acc_dev_ff;
  logic [15:0]     acc_addr_ff;
  logic [15:0]     acc_wdata_ff;

  logic        mdc_rise;
  logic        mdc_fall;
  logic        bit_in;
  logic [11:0] hdr_full;
  logic        hdr_match;
  logic        rd_go;
  logic        wr_go;
  logic [15:0] wr_word;
  logic [4:0]  reg_sel;
  logic [1:0]  func;
  logic [4:0]  dev;
  logic        dev_ok;
  logic        to_ctrl;
  logic        to_win;
  logic        win_ptr;
  logic        win_data;
  logic        ind_std;
  logic        ind_blocked;
  logic        ext_go;
  logic        std_go;
  logic        user_access;

  // Pin synchronisers; edges found from the second stage only
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdc_meta_ff  <= 1'b0;
      mdc_sync_ff  <= 1'b0;
      mdc_prev_ff  <= 1'b0;
      mdio_meta_ff <= 1'b1;
      mdio_sync_ff <= 1'b1;
    end else begin
      mdc_meta_ff  <= link.mdc;
      mdc_sync_ff  <= mdc_meta_ff;
      mdc_prev_ff  <= mdc_sync_ff;
      mdio_meta_ff <= link.mdio;
      mdio_sync_ff <= mdio_meta_ff;
    end
  end

  // Only management clock edges advance the frame; no count of idle time
  assign mdc_rise = mdc_sync_ff & ~mdc_prev_ff;
  assign mdc_fall = ~mdc_sync_ff & mdc_prev_ff;
  assign bit_in   = mdio_sync_ff;

  // Strap address taken once the synchronised straps have settled
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_meta_ff <= 3'h0;
      strap_sync_ff <= 3'h0;
      strap_cnt_ff  <= 2'h0;
      addr_ff       <= 3'h0;
    end else begin
      strap_meta_ff <= strap_addr_i;
      strap_sync_ff <= strap_meta_ff;
      if (strap_cnt_ff != 2'h3) begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
      if (strap_cnt_ff == 2'h2) begin
        addr_ff <= strap_sync_ff;
      end
    end
  end

  assign hdr_full  = {hdr_ff[10:0], bit_in};
  assign hdr_match = (hdr_full[9:5] == {2'b00, addr_ff}) &&
                     (hdr_full[11:10] == OP_READ || hdr_full[11:10] == OP_WRITE);

  // Frame sequencer
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff    <= ST_IDLE;
      cnt_ff      <= 5'h00;
      hdr_ff      <= 12'h000;
      last_bit_ff <= 1'b1;
      hit_ff      <= 1'b0;
      is_read_ff  <= 1'b0;
      wdata_ff    <= 16'h0000;
    end else if (mdc_rise) begin
      last_bit_ff <= bit_in;
      case (state_ff)
        ST_IDLE: begin
          if (last_bit_ff && !bit_in) begin
            state_ff <= ST_START;
          end
        end
        ST_START: begin
          cnt_ff   <= 5'h00;
          state_ff <= (bit_in == START_CODE[0]) ? ST_HDR : ST_IDLE;
        end
        ST_HDR: begin
          hdr_ff <= hdr_full;
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == 5'(HDR_BITS - 1)) begin
            state_ff   <= ST_TA;
            cnt_ff     <= 5'h00;
            hit_ff     <= hdr_match;
            is_read_ff <= (hdr_full[11:10] == OP_READ);
          end
        end
        ST_TA: begin
          cnt_ff <= cnt_ff + 5'h01;
          if (cnt_ff == 5'h01) begin
            state_ff <= ST_DATA;
            cnt_ff   <= 5'h00;
          end
        end
        ST_DATA: begin
          wdata_ff <= {wdata_ff[14:0], bit_in};
          cnt_ff   <= cnt_ff + 5'h01;
          if (cnt_ff == 5'(DATA_BITS - 1)) begin
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Read target fixed at first turnaround bit, write at the last data bit
  assign rd_go   = mdc_rise && state_ff == ST_TA && cnt_ff == 5'h00 && hit_ff && is_read_ff;
  assign wr_go   = mdc_rise && state_ff == ST_DATA && cnt_ff == 5'(DATA_BITS - 1) &&
                   hit_ff && !is_read_ff;
  assign wr_word = {wdata_ff[14:0], bit_in};

  // Access decode
  assign reg_sel     = hdr_ff[4:0];
  assign func        = ctrl_ff[CTRL_FUNC_HI:CTRL_FUNC_LO];
  assign dev         = ctrl_ff[CTRL_DEV_HI:CTRL_DEV_LO];
  assign dev_ok      = dev == DEV_VENDOR || dev == DEV_ENERGY_A || dev == DEV_ENERGY_B;
  assign to_ctrl     = reg_sel == REG_CTRL;
  assign to_win      = reg_sel == REG_WINDOW;
  assign win_ptr     = to_win && func == FUNC_ADDR && dev_ok;
  assign win_data    = to_win && func == FUNC_DATA && dev_ok;
  assign ind_std     = win_data && dev == DEV_VENDOR && ptr_ff < NUM_STD_REGS;
  assign ind_blocked = ind_std && (ptr_ff[4:0] == REG_CTRL || ptr_ff[4:0] == REG_WINDOW);
  assign ext_go      = win_data && !ind_blocked;
  assign std_go      = !to_ctrl && !to_win;
  assign user_access = std_go || ext_go;

  // Control and pointer hold between frames; no automatic advance
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RESET;
      ptr_ff  <= PTR_RESET;
    end else if (wr_go) begin
      if (to_ctrl) begin
        ctrl_ff <= wr_word;
      end
      if (win_ptr) begin
        ptr_ff <= wr_word;
      end
    end
  end

  // Access port toward the register storage
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_req_ff   <= 1'b0;
      acc_we_ff    <= 1'b0;
      acc_ext_ff   <= 1'b0;
      acc_dev_ff   <= 5'h00;
      acc_addr_ff  <= 16'h0000;
      acc_wdata_ff <= 16'h0000;
    end else begin
      acc_req_ff <= (rd_go || wr_go) && user_access;
      if ((rd_go || wr_go) && user_access) begin
        acc_we_ff    <= wr_go;
        acc_ext_ff   <= win_data && !ind_std;
        acc_dev_ff   <= dev;
        acc_addr_ff  <= std_go ? {11'h000, reg_sel} : ptr_ff;
        acc_wdata_ff <= wr_word;
      end
    end
  end

  // Read word: internal registers at once, storage one cycle after request
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_pend_ff <= 1'b0;
      rd_data_ff <= 16'h0000;
    end else begin
      rd_pend_ff <= acc_req_ff && !acc_we_ff;
      if (rd_pend_ff) begin
        rd_data_ff <= acc_rdata_i;
      end else if (rd_go) begin
        if (to_ctrl) begin
          rd_data_ff <= ctrl_ff;
        end else if (win_ptr) begin
          rd_data_ff <= ptr_ff;
        end else begin
          rd_data_ff <= 16'h0000;
        end
      end
    end
  end

  // Line driver changes on falling edges so the station sees it settled
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_ff <= 1'b0;
      oe_ff  <= 1'b0;
    end else if (mdc_fall) begin
      if (state_ff == ST_TA && cnt_ff == 5'h01 && hit_ff && is_read_ff) begin
        oe_ff  <= 1'b1;
        out_ff <= 1'b0;
      end else if (state_ff == ST_DATA && hit_ff && is_read_ff) begin
        oe_ff  <= 1'b1;
        out_ff <= rd_data_ff[4'hf - cnt_ff[3:0]];
      end else begin
        oe_ff  <= 1'b0;
        out_ff <= 1'b0;
      end
    end
  end

  assign link.phy_mdio_out = out_ff;
  assign link.phy_mdio_oe  = oe_ff;
  assign phy_addr_o        = addr_ff;
  assign ctrl_o            = ctrl_ff;
  assign ptr_o             = ptr_ff;
  assign acc_req_o         = acc_req_ff;
  assign acc_we_o          = acc_we_ff;
  assign acc_ext_o         = acc_ext_ff;
  assign acc_dev_o         = acc_dev_ff;
  assign acc_addr_o        = acc_addr_ff;
  assign acc_wdata_o       = acc_wdata_ff;
endmodule
`default_nettype wire

// ---- rtl/sta_mgmt_end.sv ----
/*
  Station end of the serial management link: makes the management clock
  by division, shifts out one read or write frame per command, collects
  read data.
  Assumes the user holds command fields while cmd_valid_i and cmd_ready_o.
*/
`timescale 1ns/1ps
`default_nettype none
module sta_mgmt_end #(
  parameter int SETTLE = mgmt_serial_pkg::SETTLE_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  mgmt_link_if.station     link,
  input  wire logic        cmd_valid_i,
  output logic             cmd_ready_o,
  input  wire logic        cmd_we_i,
  input  wire logic [4:0]  cmd_phy_i,
  input  wire logic [4:0]  cmd_reg_i,
  input  wire logic [15:0] cmd_wdata_i,
  output logic             done_o,
  output logic      [15:0] rdata_o
);
  import mgmt_serial_pkg::*;

  localparam logic [2:0] HALF_LAST = 3'(MDC_HALF_CYCLES - 1);
  localparam logic [2:0] BIT_LAST  = 3'(2 * MDC_HALF_CYCLES - 1);

  logic [SETTLE_W-1:0]   settle_ff;
  logic                  settled_ff;
  logic                  active_ff;
  logic                  rd_ff;
  logic [FRAME_BITS-1:0] frame_ff;
  logic [FRAME_BITS-1:0] mask_ff;
  logic [5:0]            idx_ff;
  logic [2:0]            div_ff;
  logic                  mdc_ff;
  logic                  out_ff;
  logic                  oe_ff;
  logic                  mdio_meta_ff;
  logic                  mdio_sync_ff;
  logic [15:0]           rx_ff;
  logic                  done_ff;
  logic [15:0]           rdata_ff;
  logic                  accept;

  // Bus kept quiet for the settle time after reset
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      settle_ff  <= '0;
      settled_ff <= 1'b0;
    end else if (!settled_ff) begin
      settle_ff  <= settle_ff + 1'b1;
      settled_ff <= (settle_ff == SETTLE_W'(SETTLE - 1));
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mdio_meta_ff <= 1'b1;
      mdio_sync_ff <= 1'b1;
    end else begin
      mdio_meta_ff <= link.mdio;
      mdio_sync_ff <= mdio_meta_ff;
    end
  end

  assign cmd_ready_o = settled_ff && !active_ff;
  assign accept      = cmd_valid_i && cmd_ready_o;

  // Frame shifter; clock runs only during a frame
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_ff <= 1'b0;
      rd_ff     <= 1'b0;
      frame_ff  <= '0;
      mask_ff   <= '0;
      idx_ff    <= 6'h00;
      div_ff    <= 3'h0;
      mdc_ff    <= 1'b0;
      out_ff    <= 1'b1;
      oe_ff     <= 1'b0;
      rx_ff     <= 16'h0000;
      done_ff   <= 1'b0;
      rdata_ff  <= 16'h0000;
    end else begin
      done_ff <= 1'b0;
      if (accept) begin
        active_ff <= 1'b1;
        rd_ff     <= !cmd_we_i;
        idx_ff    <= 6'h00;
        div_ff    <= 3'h0;
        // Idle, start, op, address, register, turnaround, data, idle
        frame_ff  <= {1'b1, START_CODE, cmd_we_i ? OP_WRITE : OP_READ, cmd_phy_i,
                      cmd_reg_i, cmd_we_i ? TA_WRITE : 2'b11,
                      cmd_we_i ? cmd_wdata_i : 16'hffff, 1'b1};
        mask_ff   <= cmd_we_i ? {{(FRAME_BITS - 1){1'b1}}, 1'b0}
                              : {{STA_DRIVE_RD{1'b1}}, {(FRAME_BITS - STA_DRIVE_RD){1'b0}}};
      end else if (active_ff) begin
        div_ff <= div_ff + 3'h1;
        if (div_ff == 3'h0) begin
          out_ff <= frame_ff[FRAME_BITS-1];
          oe_ff  <= mask_ff[FRAME_BITS-1];
        end
        if (div_ff == HALF_LAST) begin
          mdc_ff <= 1'b1;
        end
        if (div_ff == BIT_LAST) begin
          // Falling edge closes the bit, so low and high phases are equal
          mdc_ff   <= 1'b0;
          div_ff   <= 3'h0;
          frame_ff <= {frame_ff[FRAME_BITS-2:0], 1'b1};
          mask_ff  <= {mask_ff[FRAME_BITS-2:0], 1'b0};
          idx_ff   <= idx_ff + 6'h01;
          // Read bits taken late in the high phase, past the pin delay
          if (rd_ff && idx_ff >= 6'(RD_DATA_FIRST) && idx_ff <= 6'(RD_DATA_LAST)) begin
            rx_ff <= {rx_ff[14:0], mdio_sync_ff};
          end
          if (idx_ff == 6'(FRAME_BITS - 1)) begin
            active_ff <= 1'b0;
            mdc_ff    <= 1'b0;
            oe_ff     <= 1'b0;
            out_ff    <= 1'b1;
            done_ff   <= 1'b1;
            rdata_ff  <= rx_ff;
          end
        end
      end
    end
  end

  assign link.mdc          = mdc_ff;
  assign link.sta_mdio_out = out_ff;
  assign link.sta_mdio_oe  = oe_ff;
  assign done_o            = done_ff;
  assign rdata_o           = rdata_ff;
endmodule
`default_nettype wire

// ---- tb/mgmt_link_props.sv ----
/*
  Concurrent checks on the serial management link between station and device.
  Assumes both ends share mclk_i and rst_n_i, and mdc half periods of 4 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_link_props (
  input  wire logic mclk_i,
  input  wire logic rst_n_i,
  input  wire logic mdc,
  input  wire logic sta_mdio_out,
  input  wire logic sta_mdio_oe,
  input  wire logic phy_mdio_out,
  input  wire logic phy_mdio_oe,
  input  wire logic mdio
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  logic [7:0] oe_cnt_ff;

  // Length of each device drive burst
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_cnt_ff <= 8'h00;
    end else begin
      oe_cnt_ff <= phy_mdio_oe ? oe_cnt_ff + 8'h01 : 8'h00;
    end
  end

  sequence wr_op_s;
    $rose(sta_mdio_oe) ##24 !sta_mdio_out ##8 sta_mdio_out;
  endsequence

  sequence rd_op_s;
    $rose(sta_mdio_oe) ##24 sta_mdio_out ##8 !sta_mdio_out;
  endsequence

  chk_no_contention: assert property (!(sta_mdio_oe && phy_mdio_oe))
    else $error("both ends drive the data line");
  chk_mdc_high: assert property ($rose(mdc) |-> mdc[*4] ##1 !mdc)
    else $error("management clock high phase wrong");
  chk_mdc_low: assert property ($fell(mdc) |-> !mdc[*4])
    else $error("management clock low phase too short");
  chk_sta_hold: assert property (mdc && $past(mdc) && sta_mdio_oe |-> $stable(sta_mdio_out))
    else $error("station data moved while clock high");
  chk_phy_hold: assert property (mdc && $past(mdc) && phy_mdio_oe |-> $stable(phy_mdio_out))
    else $error("device data moved while clock high");
  chk_start_code: assert property ($rose(sta_mdio_oe) |-> sta_mdio_out ##8 !sta_mdio_out ##8 sta_mdio_out)
    else $error("frame does not open with idle then 01");
  chk_ta_zero: assert property ($rose(phy_mdio_oe) |-> !mdc && !phy_mdio_out && !mdio)
    else $error("device drive does not start with zero");
  chk_read_len: assert property ($fell(phy_mdio_oe) |-> oe_cnt_ff inside {[8'h86:8'h8a]})
    else $error("device drive burst not 17 bits long");
  chk_write_ta: assert property (wr_op_s |-> ##88 (sta_mdio_oe && sta_mdio_out) ##8 (sta_mdio_oe && !sta_mdio_out))
    else $error("write turnaround not 10 from station");
  chk_read_ta: assert property (rd_op_s |-> ##88 (!sta_mdio_oe && !phy_mdio_oe) ##8 !sta_mdio_oe)
    else $error("read turnaround first bit driven");

  cover property (wr_op_s);
  cover property (rd_op_s);
  cover property ($fell(phy_mdio_oe));
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
/*
  Self-checking bench: station end and device end joined by the link,
  a register store behind the device, a model of control and pointer.
  Assumes a short settle count and the link checker beside the interface.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mgmt_serial_pkg::*;
  localparam logic [4:0] DEVS [4] = '{DEV_VENDOR, DEV_ENERGY_A, DEV_ENERGY_B, 5'h05};
  localparam logic [4:0] STDP [3] = '{5'h03, REG_CTRL, REG_WINDOW};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        cmd_we = 1'b0;
  logic [4:0]  cmd_phy = 5'h00;
  logic [4:0]  cmd_reg = 5'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [15:0] acc_rdata = 16'h0000;
  logic [2:0]  strap = 3'h5;
  logic        cmd_ready, done, acc_req, acc_we, acc_ext;
  logic [15:0] rdata, ctrl, ptr, acc_addr, acc_wdata;
  logic [4:0]  acc_dev, me;
  logic [2:0]  phy_addr;
  logic [21:0] akey;
  logic [15:0] n_acc = 16'h0000;
  logic [15:0] exp_acc = 16'h0000;
  logic [15:0] exp_ctrl, exp_ptr;
  logic [15:0] store [logic [21:0]];
  logic [15:0] model [logic [21:0]];
  int          n_errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  mgmt_link_if link ();
  sta_mgmt_end #(.SETTLE(16)) u_sta_mgmt_end (.mclk_i(mclk), .rst_n_i(rst_n),
    .link(link.station), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_we_i(cmd_we),
    .cmd_phy_i(cmd_phy), .cmd_reg_i(cmd_reg), .cmd_wdata_i(cmd_wdata), .done_o(done),
    .rdata_o(rdata));
  phy_mgmt_end u_phy_mgmt_end (.mclk_i(mclk), .rst_n_i(rst_n), .link(link.phy),
    .strap_addr_i(strap), .phy_addr_o(phy_addr), .ctrl_o(ctrl), .ptr_o(ptr),
    .acc_req_o(acc_req), .acc_we_o(acc_we), .acc_ext_o(acc_ext), .acc_dev_o(acc_dev),
    .acc_addr_o(acc_addr), .acc_wdata_o(acc_wdata), .acc_rdata_i(acc_rdata));
  mgmt_link_props u_mgmt_link_props (.mclk_i(mclk), .rst_n_i(rst_n), .mdc(link.mdc),
    .sta_mdio_out(link.sta_mdio_out), .sta_mdio_oe(link.sta_mdio_oe),
    .phy_mdio_out(link.phy_mdio_out), .phy_mdio_oe(link.phy_mdio_oe), .mdio(link.mdio));

  always #4 mclk = ~mclk;

  function automatic logic [15:0] init_val(input logic [21:0] k);
    return k[15:0] ^ {k[21:17], 11'h5a3};
  endfunction

  // Register store behind the device: answers in the cycle after the request
  always @(posedge mclk) begin
    if (acc_req === 1'b1) begin
      akey = {acc_ext, acc_ext ? acc_dev : 5'h00, acc_addr};
      n_acc <= n_acc + 16'h0001;
      if (acc_we) store[akey] = acc_wdata;
      acc_rdata <= store.exists(akey) ? store[akey] : init_val(akey);
    end
  end

  task automatic results;
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      $display("unexpected at %0t: run did not finish", $time);
      results();
    end
  end

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic [2:0] s);
    int i;
    @(posedge mclk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    exp_ctrl = CTRL_RESET;
    exp_ptr = PTR_RESET;
    me = {2'b00, s};
    i = 0;
    do begin @(negedge mclk); i++; end while (cmd_ready !== 1'b1 && i < 100);
    cmp({15'h0000, cmd_ready}, 16'h0001);
    cmp({13'h0000, phy_addr}, {13'h0000, s});
    cmp(ctrl, CTRL_RESET);
    cmp(ptr, PTR_RESET);
  endtask

  task automatic xfer(input logic we, input logic [4:0] phy, input logic [4:0] r,
                      input logic [15:0] d);
    logic [15:0] exp_rd;
    logic [21:0] k;
    logic        hit;
    logic        std;
    int          i;
    // Idle gap with the management clock stopped
    repeat (8 + $urandom % 32) @(posedge mclk);
    cmp(n_acc, exp_acc);
    cmp(ctrl, exp_ctrl);
    cmp(ptr, exp_ptr);
    cmp({14'h0000, link.mdc, link.mdio}, 16'h0001);
    exp_rd = 16'hffff;
    hit = 1'b0;
    k = {6'h00, 11'h000, r};
    std = exp_ctrl[4:0] == DEV_VENDOR && exp_ptr < NUM_STD_REGS;
    if (phy === me) begin
      exp_rd = 16'h0000;
      if (r == REG_CTRL) begin
        if (we) exp_ctrl = d;
        exp_rd = exp_ctrl;
      end else if (r == REG_WINDOW) begin
        if (exp_ctrl[CTRL_FUNC_HI:CTRL_FUNC_LO] == FUNC_ADDR &&
            exp_ctrl[4:0] inside {DEV_VENDOR, DEV_ENERGY_A, DEV_ENERGY_B}) begin
          if (we) exp_ptr = d;
          exp_rd = exp_ptr;
        end else if (exp_ctrl[CTRL_FUNC_HI:CTRL_FUNC_LO] == FUNC_DATA &&
                     exp_ctrl[4:0] inside {DEV_VENDOR, DEV_ENERGY_A, DEV_ENERGY_B}) begin
          hit = !(std && exp_ptr[4:0] inside {REG_CTRL, REG_WINDOW});
          k = std ? {6'h00, exp_ptr} : {1'b1, exp_ctrl[4:0], exp_ptr};
        end
      end else begin
        hit = 1'b1;
      end
    end
    if (hit) begin
      exp_acc = exp_acc + 16'h0001;
      if (we) model[k] = d;
      exp_rd = model.exists(k) ? model[k] : init_val(k);
    end
    cmd_we <= we;
    cmd_phy <= phy;
    cmd_reg <= r;
    cmd_wdata <= d;
    cmd_valid <= 1'b1;
    i = 0;
    do begin @(negedge mclk); i++; end while (cmd_ready !== 1'b1 && i < 1000);
    @(posedge mclk);
    cmd_valid <= 1'b0;
    i = 0;
    do begin @(negedge mclk); i++; end while (done !== 1'b1 && i < 400);
    cmp({15'h0000, done}, 16'h0001);
    if (!we) cmp(rdata, exp_rd);
  endtask

  initial begin
    logic [4:0] r;
    void'($urandom(32'h7bdb2889));
    do_reset(3'h5);
    for (int n = 0; n < 24; n++) begin
      r = 5'($urandom % 32);
      xfer(1'($urandom), me, r, 16'($urandom));
    end
    xfer(1'b0, {2'b00, me[2:0] ^ 3'h1}, 5'h02, 16'h0000);
    xfer(1'b1, {2'b10, me[2:0]}, 5'h02, 16'($urandom));
    xfer(1'b0, me, 5'h02, 16'h0000);
    foreach (DEVS[j]) begin
      xfer(1'b1, me, REG_CTRL, {FUNC_ADDR, 9'h000, DEVS[j]});
      xfer(1'b1, me, REG_WINDOW, 16'h0100 + 16'($urandom % 3840));
      xfer(1'b0, me, REG_WINDOW, 16'h0000);
      xfer(1'b1, me, REG_CTRL, {FUNC_DATA, 9'h000, DEVS[j]});
      xfer(1'b1, me, REG_WINDOW, 16'($urandom));
      repeat (2) xfer(1'b0, me, REG_WINDOW, 16'h0000);
    end
    foreach (STDP[j]) begin
      xfer(1'b1, me, REG_CTRL, 16'h001f);
      xfer(1'b1, me, REG_WINDOW, {11'h000, STDP[j]});
      xfer(1'b1, me, REG_CTRL, 16'h401f);
      xfer(1'b1, me, REG_WINDOW, 16'($urandom));
      xfer(1'b0, me, STDP[j], 16'h0000);
    end
    do_reset(3'h2);
    xfer(1'b0, me, REG_CTRL, 16'h0000);
    xfer(1'b1, me, 5'h1f, 16'($urandom));
    xfer(1'b0, me, 5'h1f, 16'h0000);
    xfer(1'b0, {2'b00, 3'h5}, 5'h1f, 16'h0000);
    repeat (40) @(posedge mclk);
    cmp(n_acc, exp_acc);
    results();
  end
endmodule
`default_nettype wire
